/* hw/qpsc_pkg.sv */
package qpsc_pkg;
  localparam int FRAME_BITS = 16;
  localparam int WIPER_BITS = 6;
  localparam int CHANNELS = 4;
  localparam int TAPS = 64;
  localparam int NV_WORDS = 16;
  localparam logic [5:0] WIPER_FULL = 6'h3f;
  localparam logic [5:0] WIPER_MID = 6'h20;
  localparam logic [5:0] WIPER_ONE = 6'h01;
  localparam logic [7:0] NV_RESET_VALUE = 8'h20;
  localparam logic [3:0] SPARE_FIRST_ADDR = 4'h5;
  localparam logic [3:0] DOUT_ADDR = 4'h4;
  localparam logic [3:0] CMD_NOP = 4'h0;
  localparam logic [3:0] CMD_RESTORE = 4'h1;
  localparam logic [3:0] CMD_STORE = 4'h2;
  localparam logic [3:0] CMD_SPARE_WR = 4'h3;
  localparam logic [3:0] CMD_NV_READ = 4'h9;
  localparam logic [3:0] CMD_WIPER_READ = 4'ha;
  localparam logic [3:0] CMD_WRITE = 4'hb;
  localparam logic [3:0] CMD_SHIFT_UP = 4'hc;
  localparam logic [3:0] CMD_INC = 4'he;
  typedef enum logic [1:0] {QPSC_BOOT, QPSC_IDLE, QPSC_RESTORE} qpsc_state_t;
endpackage : qpsc_pkg

/* hw/qpsc_tap_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
module qpsc_tap_decoder
  import qpsc_pkg::*;
(
  input wire logic [WIPER_BITS-1:0] code_in, // Wiper code
  output logic [TAPS-1:0] tap_out // One-hot tap, bit 0 at the B end
);
  genvar t;
  generate
    for (t = 0; t < TAPS; t++)
    begin : g_tap
      // R1: one-hot tap select
      // R2: higher code toward A
      assign tap_out[t] = (code_in == WIPER_BITS'(t));
    end
  endgenerate
endmodule : qpsc_tap_decoder
`default_nettype wire

/* hw/qpsc_core.sv */
`timescale 1ns/1ps
`default_nettype none
// Operation
// R1: each channel's 6-bit code selects exactly one of 64 taps, zero at B.
// R2: each code step moves the tap toward A; code 63 is full scale.
// R3: frames are 16 bits: instruction, address, data byte, MSB first.
// R4: instruction B loads the data byte into the addressed wiper.
// R5: SDO returns the previous frame unless a read was prepared.
// R6: instruction E increments the addressed wiper, data ignored.
// R7: instruction 2 copies the wiper into its nonvolatile slot.
// R8: write-protect low blocks every nonvolatile write.
// R9: instruction 1 copies the nonvolatile slot back into the wiper.
// R10: stored wipers reload at reset and on preset-restore strobe.
// R11: controller sends a no-op frame after restore or read preparation.
// R12: instruction C doubles the addressed wiper, data ignored.
// R13: doubling midscale gives full scale, never overflow.
// R14: instruction 3 writes the data byte into the addressed spare byte.
// R15: instruction 9 fetches a nonvolatile byte for the next frame.
// R16: after read preparation SDO sends command byte and fetched byte.
// R17: instruction A prepares the wiper value for next frame readout.
// R18: doubling zero gives one; doubling at or above midscale gives 63.
// R19: addresses 5 to 15 are spare bytes; 0-3 wipers, 4 output bits.
// R20: a frame executes at chip-select release after exactly 16 clocks.
// R21: increments saturate at 63; codes stay within six bits.
module qpsc_core
  import qpsc_pkg::*;
(
  input wire logic clk_in, // System clock, 100 MHz
  input wire logic reset_in, // Synchronous reset, high
  input wire logic sclk_in, // Serial clock from controller
  input wire logic cs_n_in, // Chip select, low active
  input wire logic sdi_in, // Serial data in
  output logic sdo_out, // Serial data out
  input wire logic wp_n_in, // Write protect, low blocks nonvolatile writes
  input wire logic pr_n_in, // Preset restore strobe, low active
  output logic [TAPS*CHANNELS-1:0] taps_out, // One-hot taps, channel 0 lowest
  output logic [1:0] dout_out // Digital output bits
);
  // Link domain: shifting on sclk. Capture on rising, drive on falling.
  logic [FRAME_BITS-1:0] shift_r;
  logic [4:0] bitcnt_r;
  logic [FRAME_BITS-1:0] frame_r;
  // Toggle needs a known start; the link side has no reset of its own
  logic frame_tgl_r = 1'b0;
  logic frame_len_ok_r;
  logic [FRAME_BITS-1:0] out_shift_r;
  logic [FRAME_BITS-1:0] reply_r;
  logic first_r;
  wire [FRAME_BITS-1:0] shift_next = {shift_r[FRAME_BITS-2:0], sdi_in};
  wire [4:0] bitcnt_next = bitcnt_r + 5'h01;
  wire bitcnt_full = (bitcnt_r == 5'h1f);

  // Select release clears the count even though sclk is parked then
  always_ff @(posedge sclk_in or posedge cs_n_in)
  begin
    if (cs_n_in)
    begin
      bitcnt_r <= 5'h00;
    end
    else
    begin
      bitcnt_r <= bitcnt_full ? bitcnt_r : bitcnt_next;
    end
  end

  // R3: MSB-first sixteen-bit shift
  always_ff @(posedge sclk_in)
  begin
    shift_r <= shift_next;
    // Frame is handed over on its sixteenth edge; shorter frames never get here
    if (bitcnt_r == 5'h0f)
    begin
      frame_r <= shift_next;
      frame_tgl_r <= ~frame_tgl_r;
    end
  end

  // R20: edge count at release; settled long before the release is synced
  always_ff @(posedge cs_n_in)
  begin
    frame_len_ok_r <= (bitcnt_r == 5'h10);
  end

  // First falling edge of a frame loads the reply, later ones shift it
  always_ff @(negedge sclk_in or posedge cs_n_in)
  begin
    if (cs_n_in)
    begin
      first_r <= 1'b1;
    end
    else
    begin
      first_r <= 1'b0;
    end
  end

  // Reply is read as a word: it only changes after a select release, so
  // it stands still for the whole of the next frame
  always_ff @(negedge sclk_in)
  begin
    if (first_r)
    begin
      out_shift_r <= {reply_r[FRAME_BITS-2:0], 1'b0};
    end
    else
    begin
      out_shift_r <= {out_shift_r[FRAME_BITS-2:0], 1'b0};
    end
  end
  // R5: old frame or read data
  assign sdo_out = first_r ? reply_r[FRAME_BITS-1] : out_shift_r[FRAME_BITS-1];

  // System domain
  logic [2:0] tgl_sync_r;
  logic tgl_seen_r;
  logic [2:0] cs_sync_r;
  logic [2:0] pr_sync_r;
  logic [2:0] wp_sync_r;
  logic pend_r;
  logic pend_nxt;
  logic cs_level_r;
  logic pr_level_r;
  logic wp_level_r;
  logic [FRAME_BITS-1:0] cmd_r;
  logic [WIPER_BITS-1:0] wiper_r [CHANNELS];
  logic [7:0] nv_r [NV_WORDS] = '{default: NV_RESET_VALUE};
  qpsc_state_t state_r;
  logic [2:0] rcnt_r;

  always_ff @(posedge clk_in)
  begin
    tgl_sync_r <= {tgl_sync_r[1:0], frame_tgl_r};
    cs_sync_r <= {cs_sync_r[1:0], cs_n_in};
    pr_sync_r <= {pr_sync_r[1:0], pr_n_in};
    wp_sync_r <= {wp_sync_r[1:0], wp_n_in};
  end

  // Changes count once the second and third stages agree
  wire tgl_stable = (tgl_sync_r[1] == tgl_sync_r[2]);
  wire new_frame = tgl_stable && (tgl_sync_r[2] != tgl_seen_r);
  wire cs_stable = (cs_sync_r[1] == cs_sync_r[2]);
  wire cs_rise = cs_stable && cs_sync_r[2] && !cs_level_r;
  wire pr_stable = (pr_sync_r[1] == pr_sync_r[2]);
  wire pr_fall = pr_stable && !pr_sync_r[2] && pr_level_r;
  // Write protect acts on every nonvolatile write, store and spare alike
  wire wp_ok = wp_level_r;

  wire [3:0] op = cmd_r[15:12];
  wire [3:0] addr = cmd_r[11:8];
  wire [7:0] data = cmd_r[7:0];
  wire [1:0] ch = addr[1:0];
  wire ch_ok = (addr < 4'(CHANNELS));
  wire [WIPER_BITS-1:0] cur = wiper_r[ch];
  // R21: saturating increment
  wire [WIPER_BITS-1:0] inc_val = (cur == WIPER_FULL) ? WIPER_FULL : cur + WIPER_ONE;
  // R13: midscale doubles to full
  // R18: zero to one, top half saturates
  wire [WIPER_BITS-1:0] shl_val = (cur == 6'h00) ? WIPER_ONE :
                                  (cur >= WIPER_MID) ? WIPER_FULL : {cur[4:0], 1'b0};
  // R20: execute at chip-select release after full frame
  wire exec = (state_r == QPSC_IDLE) && pend_r && cs_rise && frame_len_ok_r;

  // A release with no new frame clears a stale pending flag
  always_comb
  begin
    pend_nxt = pend_r;
    if (new_frame)
    begin
      pend_nxt = 1'b1;
    end
    else if (exec || (cs_rise && !new_frame))
    begin
      pend_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      tgl_seen_r <= 1'b0;
      cs_level_r <= 1'b1;
      pr_level_r <= 1'b1;
      wp_level_r <= 1'b1;
      pend_r <= 1'b0;
      cmd_r <= 16'h0000;
      reply_r <= 16'h0000;
      state_r <= QPSC_BOOT;
      rcnt_r <= 3'h0;
      dout_out <= 2'h0;
      for (int i = 0; i < CHANNELS; i++)
      begin
        wiper_r[i] <= WIPER_MID;
      end
    end
    else
    begin
      if (tgl_stable)
      begin
        tgl_seen_r <= tgl_sync_r[2];
      end
      if (cs_stable)
      begin
        cs_level_r <= cs_sync_r[2];
      end
      if (pr_stable)
      begin
        pr_level_r <= pr_sync_r[2];
      end
      if (wp_sync_r[1] == wp_sync_r[2])
      begin
        wp_level_r <= wp_sync_r[2];
      end
      if (new_frame)
      begin
        cmd_r <= frame_r;
      end
      pend_r <= pend_nxt;
      case (state_r)
        // R10: reload stored wipers
        QPSC_BOOT, QPSC_RESTORE:
        begin
          wiper_r[rcnt_r[1:0]] <= nv_r[rcnt_r[1:0]][WIPER_BITS-1:0];
          dout_out <= nv_r[DOUT_ADDR][1:0];
          rcnt_r <= rcnt_r + 3'h1;
          if (rcnt_r == 3'h3)
          begin
            state_r <= QPSC_IDLE;
            rcnt_r <= 3'h0;
          end
        end
        QPSC_IDLE:
        begin
          if (pr_fall)
          begin
            state_r <= QPSC_RESTORE;
          end
          else if (exec)
          begin
            // R5: default reply is the frame itself
            reply_r <= cmd_r;
            case (op)
              // R4: direct load
              CMD_WRITE: if (ch_ok) wiper_r[ch] <= data[WIPER_BITS-1:0];
              // R6: increment
              CMD_INC: if (ch_ok) wiper_r[ch] <= inc_val;
              // R12: left shift
              CMD_SHIFT_UP: if (ch_ok) wiper_r[ch] <= shl_val;
              // R9: slot back to wiper
              CMD_RESTORE: if (ch_ok) wiper_r[ch] <= nv_r[ch][WIPER_BITS-1:0];
              // R15: fetch nonvolatile byte
              // R16: command byte then fetched byte
              CMD_NV_READ: reply_r <= {cmd_r[15:8], nv_r[addr]};
              // R17: wiper readout prepared
              CMD_WIPER_READ: reply_r <= {cmd_r[15:8], 2'b00, cur};
              default: ;
            endcase
          end
        end
        default: state_r <= QPSC_BOOT;
      endcase
    end
  end

  // Nonvolatile array keeps contents across logic reset
  wire nv_store = exec && wp_ok && (op == CMD_STORE) && ch_ok;
  // R19: spare bytes at 5 and above
  wire nv_spare = exec && wp_ok && (op == CMD_SPARE_WR) && (addr >= SPARE_FIRST_ADDR);
  genvar n;
  generate
    for (n = 0; n < NV_WORDS; n++)
    begin : g_nv
      always_ff @(posedge clk_in)
      begin
        // R8: write protect gates writes
        // R7: wiper into its slot
        if (nv_store && (addr == 4'(n)))
        begin
          nv_r[n] <= {2'b00, cur};
        end
        // R14: spare byte write
        else if (nv_spare && (addr == 4'(n)))
        begin
          nv_r[n] <= data;
        end
      end
    end
  endgenerate

  genvar c;
  generate
    for (c = 0; c < CHANNELS; c++)
    begin : g_ch
      qpsc_tap_decoder u_dec (
        .code_in(wiper_r[c]),
        .tap_out(taps_out[c*TAPS +: TAPS])
      );
    end
  endgenerate
endmodule : qpsc_core
`default_nettype wire

/* verification/qpsc_core_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module qpsc_core_properties
  import qpsc_pkg::*;
(
  input wire logic clk_in, // Clock
  input wire logic reset_in, // Reset
  input wire logic cs_n_in, // Select
  input wire logic pr_n_in, // Restore strobe
  input wire logic [TAPS*CHANNELS-1:0] taps_out, // Taps
  input wire logic [1:0] dout_out // Output bits
);
  logic [4:0] quiet_r;
  logic [4:0] quiet_nxt;
  // Cycles since a frame end, strobe or reset; saturates so it never wraps
  assign quiet_nxt = (quiet_r == 5'h1f) ? quiet_r : quiet_r + 5'h01;
  always_ff @(posedge clk_in)
    quiet_r <= (reset_in || $rose(cs_n_in) || $fell(pr_n_in)) ? 5'h00 : quiet_nxt;
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  AST_ONEHOT_0: assert property ($onehot(taps_out[63:0])) else $error("tap 0 bad");
  AST_ONEHOT_1: assert property ($onehot(taps_out[127:64])) else $error("tap 1 bad");
  AST_ONEHOT_2: assert property ($onehot(taps_out[191:128])) else $error("tap 2 bad");
  AST_ONEHOT_3: assert property ($onehot(taps_out[255:192])) else $error("tap 3 bad");
  AST_RESET_MID: assert property ($fell(reset_in) |->
    taps_out[32] && taps_out[96] && taps_out[160] && taps_out[224]) else $error("no midscale");
  AST_TAPS_QUIET: assert property (quiet_r > 5'h0c |-> $stable(taps_out))
    else $error("taps moved idle");
  AST_DOUT_QUIET: assert property (quiet_r > 5'h0c |-> $stable(dout_out))
    else $error("outputs moved idle");
  AST_NO_EARLY: assert property (quiet_r > 5'h0c && $rose(cs_n_in) |=> $stable(taps_out))
    else $error("taps moved early");
endmodule : qpsc_core_properties
bind qpsc_core qpsc_core_properties u_props (.clk_in(clk_in), .reset_in(reset_in),
  .cs_n_in(cs_n_in), .pr_n_in(pr_n_in), .taps_out(taps_out), .dout_out(dout_out));
`default_nettype wire

/* verification/qpsc_spi_master.sv */
`timescale 1ns/1ps
`default_nettype none
module qpsc_spi_master
(
  input wire logic sdo_in, // Reply bit
  output var logic sclk_out, // Link clock, idle low
  output var logic cs_n_out, // Select, low active
  output var logic sdi_out // Command bit
);
  initial
  begin
    sclk_out = 1'b0;
    sdi_out = 1'b0;
    // Brief select pulse gives the link side one release edge to start from
    cs_n_out = 1'b0;
    #1;
    cs_n_out = 1'b1;
  end
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    cs_n_out = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      sdi_out = tx[i];
      #24;
      sclk_out = 1'b1;
      rx[i] = sdo_in;
      #24;
      sclk_out = 1'b0;
    end
    #24;
    cs_n_out = 1'b1;
    // Stale bit inverted so it cannot pass as data
    sdi_out = ~sdi_out;
  endtask : xfer
endmodule : qpsc_spi_master
`default_nettype wire

/* verification/qpsc_core_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module qpsc_core_tb;
  logic clk_in, reset_in, wp_n_in, pr_n_in, sclk, cs_n, sdi, sdo;
  logic [255:0] taps;
  logic [1:0] dout;
  logic [15:0] rx;
  int n_mismatch, check_count;
  qpsc_core uut (.clk_in(clk_in), .reset_in(reset_in), .sclk_in(sclk), .cs_n_in(cs_n),
    .sdi_in(sdi), .sdo_out(sdo), .wp_n_in(wp_n_in), .pr_n_in(pr_n_in), .taps_out(taps),
    .dout_out(dout));
  qpsc_spi_master spi (.sdo_in(sdo), .sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi));
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  task automatic test_done;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done
  task automatic tally(input bit ok, input string what);
    check_count++;
    if (!ok)
    begin
      n_mismatch++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask : tally
  task automatic chk_rx(input logic [15:0] exp);
    tally(rx === exp, "reply");
  endtask : chk_rx
  task automatic chk_tap(input int ch, input logic [5:0] code);
    tally(taps[ch*64 +: 64] === (64'h1 << code), "tap");
  endtask : chk_tap
  task automatic chk_dout(input logic [1:0] exp);
    tally(dout === exp, "dout");
  endtask : chk_dout
  // Gap leaves room for the execution after select rises
  task automatic fr(input logic [15:0] tx);
    spi.xfer(tx, rx);
    repeat (12) @(negedge clk_in);
  endtask : fr
  task automatic t_write;
    for (int c = 0; c < 4; c++)
    begin
      fr({4'hb, 4'(c), 8'(c * 21)});
      chk_tap(c, 6'(c * 21));
    end
    fr(16'hb010);
    chk_tap(0, 6'h10);
    fr(16'he0ff);
    chk_rx(16'hb010);
    chk_tap(0, 6'h11);
    fr(16'hb03e);
    fr(16'he000);
    fr(16'he000);
    chk_tap(0, 6'h3f);
  endtask : t_write
  task automatic t_shift;
    fr(16'hb110);
    fr(16'hc1ff);
    chk_tap(1, 6'h20);
    fr(16'hb100);
    fr(16'hc100);
    chk_tap(1, 6'h01);
    fr(16'hb020);
    fr(16'hc000);
    fr(16'ha000);
    fr(16'h0000);
    chk_rx(16'ha03f);
  endtask : t_shift
  task automatic t_nv;
    fr(16'hb215);
    fr(16'h2200);
    fr(16'hb200);
    fr(16'h1200);
    chk_tap(2, 6'h15);
    wp_n_in = 1'b0;
    fr(16'hb22a);
    fr(16'h2200);
    fr(16'h1200);
    fr(16'h0000);
    chk_tap(2, 6'h15);
    wp_n_in = 1'b1;
    fr(16'hb233);
    pr_n_in = 1'b0;
    repeat (4) @(negedge clk_in);
    pr_n_in = 1'b1;
    repeat (12) @(negedge clk_in);
    chk_tap(2, 6'h15);
    chk_dout(qpsc_pkg::NV_RESET_VALUE[1:0]);
  endtask : t_nv
  task automatic t_spare;
    fr(16'h35aa);
    fr(16'h3655);
    chk_rx(16'h35aa);
    fr(16'h3f77);
    fr(16'h3477);
    fr(16'h9500);
    fr(16'h9f00);
    chk_rx(16'h95aa);
    fr(16'h9400);
    chk_rx(16'h9f77);
    fr(16'h0000);
    chk_rx(16'h9420);
  endtask : t_spare
  initial
  begin
    reset_in = 1'b1;
    wp_n_in = 1'b1;
    pr_n_in = 1'b1;
    repeat (12) @(negedge clk_in);
    reset_in = 1'b0;
    repeat (12) @(negedge clk_in);
    t_write();
    t_shift();
    t_nv();
    t_spare();
    test_done();
  end
  initial
  begin
    #200000;
    n_mismatch++;
    test_done();
  end
endmodule : qpsc_core_tb
`default_nettype wire
